// ===== rtl/acdf_top.sv
// Clock divider, power control and serial output formatter for eight channels
`include "acdf_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module acdf_top
	import acdf_pkg::*;
#(
	parameter int        CLK_IN_HZ  = `ACDF_CLK_HZ,
	parameter int        FIFO_DEPTH = 4,
	parameter logic [2:0] DIV_RESET = 3'h0
) (
	input  wire logic                      CLOCK,
	input  wire logic                      RST_B,
	input  wire logic                      SYNC_IN,
	input  wire logic                      POWER_DOWN_PIN,
	input  wire logic [7:0][15:0]          ADC_SAMPLE,
	input  wire logic                      REG_WE,
	input  wire logic                      REG_RE,
	input  wire logic [`ACDF_ADDR_W-1:0]   REG_ADDR,
	input  wire logic [7:0]                REG_WDATA,
	output logic      [7:0]                REG_RDATA,
	output logic                           SAMPLE_CLK,
	output logic                           DCS_ACTIVE,
	output logic                           DCS_LOCKED,
	output logic                           CONV_PD,
	output logic                           REF_PD,
	output logic                           DRV_REDUCED,
	output logic      [7:0]                DRV_STRENGTH,
	output logic      [7:0][1:0]           LANE_DATA,
	output logic      [1:0]                BIT_CAPTURE_CLOCK,
	output logic      [1:0]                WORD_BOUNDARY_CLOCK,
	output logic                           LANE_OE_B
);
	localparam int RELOCK_MIN_CYC =
		(`ACDF_RELOCK_MIN_NS * (CLK_IN_HZ / 1_000_000) + 999) / 1000;
	localparam int RELOCK_MAX_CYC =
		(`ACDF_RELOCK_MAX_NS * (CLK_IN_HZ / 1_000_000)) / 1000;
	localparam logic [8:0] RELOCK_CYC = 9'(RELOCK_MAX_CYC);
	localparam logic DCS_USABLE = (CLK_IN_HZ >= `ACDF_DCS_MIN_HZ);

	// Clamp a wide core result to the 14-bit range and code it
	function automatic logic [13:0] fmt_code(input logic signed [15:0] raw,
		input logic offs);
		logic signed [15:0] c;
		logic [13:0]        t;
		c = raw;
		if (raw > `ACDF_CODE_MAX) begin
			c = `ACDF_CODE_MAX;
		end else if (raw < `ACDF_CODE_MIN) begin
			c = `ACDF_CODE_MIN;
		end
		t = c[13:0];
		fmt_code = offs ? {~t[13], t[12:0]} : t;
	endfunction : fmt_code

	// Reverse a 14-bit word
	function automatic logic [13:0] rev14(input logic [13:0] w);
		for (int i = 0; i < 14; i++) begin
			rev14[i] = w[13-i];
		end
	endfunction : rev14

	logic [7:0]  pwr_r;
	logic [7:0]  clkdiv_r;
	logic [7:0]  fmt_r;
	logic [7:0]  drv_r;
	logic [7:0]  resync_r;
	logic        sync_m_r;
	logic        sync_s_r;
	logic        sync_d_r;
	logic        pin_m_r;
	logic        pin_s_r;
	logic        armed_r;
	logic        sync_ok;
	logic [2:0]  div_cnt_r;
	logic        sample_stb;
	logic [2:0]  half_cnt;
	logic [8:0]  lock_cnt_r;
	logic        pd;
	logic        overrun_r;
	logic        hold_valid_r;
	acdf_frame_t hold_r;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_pop;
	acdf_frame_t fifo_out;
	acdf_ser_t   ser_state_r;
	logic [2:0]  pair_cnt_r;
	logic [2:0]  pairs_r;
	logic [7:0][13:0] shift_r;
	logic        load;

	// Register writes; defaults after reset give standard drive and twos complement
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pwr_r    <= `ACDF_RST_BYTE;
			clkdiv_r <= {5'h00, DIV_RESET};
			fmt_r    <= `ACDF_RST_BYTE;
			drv_r    <= `ACDF_RST_BYTE;
			resync_r <= `ACDF_RST_BYTE;
		end else if (REG_WE) begin
			case (REG_ADDR)
				`ACDF_REG_PWR:    pwr_r    <= REG_WDATA;
				`ACDF_REG_CLKDIV: clkdiv_r <= {5'h00, REG_WDATA[2:0]};
				`ACDF_REG_FMT:    fmt_r    <= REG_WDATA;
				`ACDF_REG_DRV:    drv_r    <= REG_WDATA;
				`ACDF_REG_RESYNC: resync_r <= REG_WDATA;
				default: ;
			endcase
		end
	end

	// Two-stage synchronisers for the alignment and power-down pins
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			sync_m_r <= 1'b0;
			sync_s_r <= 1'b0;
			sync_d_r <= 1'b0;
			pin_m_r  <= 1'b0;
			pin_s_r  <= 1'b0;
		end else begin
			sync_m_r <= SYNC_IN;
			sync_s_r <= sync_m_r;
			sync_d_r <= sync_s_r;
			pin_m_r  <= POWER_DOWN_PIN;
			pin_s_r  <= pin_m_r;
		end
	end

	// Accepted alignment edge under the chosen resync mode
	assign sync_ok = sync_s_r && !sync_d_r && resync_r[`ACDF_RS_EN_BIT] &&
		(!resync_r[`ACDF_RS_ONCE_BIT] || armed_r);
	assign pd = pwr_r[`ACDF_PWR_PD_BIT] || pin_s_r;

	// One-shot arming: a write re-arms, the first accepted edge disarms
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			armed_r <= 1'b0;
		end else if (REG_WE && REG_ADDR == `ACDF_REG_RESYNC) begin
			armed_r <= 1'b1;
		end else if (sync_ok) begin
			armed_r <= 1'b0;
		end
	end

	// Divider counter; a valid alignment edge returns it to zero
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			div_cnt_r <= 3'h0;
		end else if (sync_ok) begin
			div_cnt_r <= 3'h0;
		end else if (div_cnt_r >= clkdiv_r[2:0]) begin
			div_cnt_r <= 3'h0;
		end else begin
			div_cnt_r <= div_cnt_r + 3'h1;
		end
	end
	assign sample_stb = (div_cnt_r == 3'h0);
	assign half_cnt   = (clkdiv_r[2:0] == 3'h0) ? 3'h1 : 3'(({1'b0, clkdiv_r[2:0]} + 4'h1) >> 1);

	// Divided clock: rising edge at count zero, falling edge regenerated mid-period
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			SAMPLE_CLK <= 1'b0;
		end else begin
			SAMPLE_CLK <= !pd && (div_cnt_r < half_cnt);
		end
	end

	// Stabiliser relock timer, restarted by power-down or a new ratio
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			lock_cnt_r <= 9'h000;
		end else if (pd || (REG_WE && REG_ADDR == `ACDF_REG_CLKDIV)) begin
			lock_cnt_r <= 9'h000;
		end else if (lock_cnt_r != RELOCK_CYC) begin
			lock_cnt_r <= lock_cnt_r + 9'h001;
		end
	end

	// Stabiliser status and power outputs
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			DCS_ACTIVE   <= 1'b0;
			DCS_LOCKED   <= 1'b0;
			CONV_PD      <= 1'b0;
			REF_PD       <= 1'b0;
			DRV_REDUCED  <= 1'b0;
			DRV_STRENGTH <= 8'h00;
		end else begin
			DCS_ACTIVE   <= DCS_USABLE && !pd;
			DCS_LOCKED   <= DCS_USABLE && !pd && (lock_cnt_r == RELOCK_CYC);
			CONV_PD      <= pd || pwr_r[`ACDF_PWR_SBY_BIT];
			REF_PD       <= pd;
			DRV_REDUCED  <= fmt_r[`ACDF_FMT_RED_BIT];
			DRV_STRENGTH <= drv_r;
		end
	end

	// Capture and code one sample per divided period
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			hold_valid_r <= 1'b0;
			hold_r       <= '0;
		end else if (pd || pwr_r[`ACDF_PWR_SBY_BIT]) begin
			hold_valid_r <= 1'b0;
		end else if (sample_stb && (!hold_valid_r || fifo_in_ready)) begin
			hold_valid_r     <= 1'b1;
			hold_r.twelve    <= fmt_r[`ACDF_FMT_12B_BIT];
			hold_r.lsb_first <= fmt_r[`ACDF_FMT_LSB_BIT];
			for (int c = 0; c < 8; c++) begin
				hold_r.code[c] <= fmt_code(ADC_SAMPLE[c], fmt_r[`ACDF_FMT_OFFS_BIT]);
			end
		end else if (fifo_in_ready) begin
			hold_valid_r <= 1'b0;
		end
	end

	// Overrun flag: sample lost to back-pressure; set wins over clear
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			overrun_r <= 1'b0;
		end else if (sample_stb && hold_valid_r && !fifo_in_ready && !pd) begin
			overrun_r <= 1'b1;
		end else if (REG_WE && REG_ADDR == `ACDF_REG_STAT && REG_WDATA[`ACDF_ST_OVR_BIT]) begin
			overrun_r <= 1'b0;
		end
	end

	acdf_fifo #(
		.WIDTH ($bits(acdf_frame_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.CLOCK     (CLOCK),
		.RST_B     (RST_B),
		.flush     (pd),
		.in_valid  (hold_valid_r),
		.in_ready  (fifo_in_ready),
		.in_data   (hold_r),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out)
	);

	// Serialiser loads a word when idle or on the last pair of the previous one
	assign load = fifo_out_valid && !pd &&
		(ser_state_r == SER_IDLE || pair_cnt_r == 3'h0);
	assign fifo_pop = load;

	// Serialiser state and word shift registers
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ser_state_r <= SER_IDLE;
			pair_cnt_r  <= 3'h0;
			pairs_r     <= `ACDF_PAIRS_14;
			shift_r     <= '0;
		end else if (pd) begin
			ser_state_r <= SER_IDLE;
			pair_cnt_r  <= 3'h0;
		end else begin
			case (ser_state_r)
				SER_IDLE, SER_SHIFT: begin
					if (load) begin
						ser_state_r <= SER_SHIFT;
						pairs_r     <= fifo_out.twelve ? `ACDF_PAIRS_12 : `ACDF_PAIRS_14;
						pair_cnt_r  <= (fifo_out.twelve ? `ACDF_PAIRS_12 : `ACDF_PAIRS_14) - 3'h1;
						for (int c = 0; c < 8; c++) begin
							if (fifo_out.twelve && fifo_out.lsb_first) begin
								shift_r[c] <= rev14(fifo_out.code[c]) << 2;
							end else if (fifo_out.lsb_first) begin
								shift_r[c] <= rev14(fifo_out.code[c]);
							end else begin
								shift_r[c] <= fifo_out.code[c];
							end
						end
					end else if (ser_state_r == SER_SHIFT && pair_cnt_r != 3'h0) begin
						pair_cnt_r <= pair_cnt_r - 3'h1;
						for (int c = 0; c < 8; c++) begin
							shift_r[c] <= {shift_r[c][11:0], 2'b00};
						end
					end else begin
						ser_state_r <= SER_IDLE;
					end
				end
				default: ser_state_r <= SER_IDLE;
			endcase
		end
	end

	// Pins: both bits of each pair, bit and word clocks, driver enable
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			LANE_DATA           <= '0;
			BIT_CAPTURE_CLOCK   <= 2'b00;
			WORD_BOUNDARY_CLOCK <= 2'b00;
			LANE_OE_B           <= 1'b1;
		end else begin
			LANE_OE_B <= pd;
			for (int c = 0; c < 8; c++) begin
				LANE_DATA[c] <= (ser_state_r == SER_SHIFT && !pd) ? shift_r[c][13:12] : 2'b00;
			end
			BIT_CAPTURE_CLOCK <= (ser_state_r == SER_SHIFT && !pd) ? 2'b10 : 2'b00;
			if (ser_state_r != SER_SHIFT || pd) begin
				WORD_BOUNDARY_CLOCK <= 2'b00;
			end else if (pair_cnt_r >= pairs_r - (pairs_r >> 1)) begin
				WORD_BOUNDARY_CLOCK <= 2'b11;
			end else if (pair_cnt_r == (pairs_r >> 1) && pairs_r[0]) begin
				WORD_BOUNDARY_CLOCK <= 2'b10;
			end else begin
				WORD_BOUNDARY_CLOCK <= 2'b00;
			end
		end
	end

	// Register read-back, one cycle after the read strobe
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RE) begin
			case (REG_ADDR)
				`ACDF_REG_PWR:    REG_RDATA <= pwr_r;
				`ACDF_REG_CLKDIV: REG_RDATA <= clkdiv_r;
				`ACDF_REG_FMT:    REG_RDATA <= fmt_r;
				`ACDF_REG_DRV:    REG_RDATA <= drv_r;
				`ACDF_REG_RESYNC: REG_RDATA <= resync_r;
				`ACDF_REG_STAT:   REG_RDATA <= {4'h0, armed_r, pd, overrun_r, DCS_LOCKED};
				default:          REG_RDATA <= 8'h00;
			endcase
		end
	end
endmodule : acdf_top
`default_nettype wire

// ===== rtl/acdf_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ACDF_DEFS_SVH
`define ACDF_DEFS_SVH
`define ACDF_ADDR_W        9
`define ACDF_REG_PWR       9'h008
`define ACDF_REG_CLKDIV    9'h00B
`define ACDF_REG_STAT      9'h00C
`define ACDF_REG_FMT       9'h014
`define ACDF_REG_DRV       9'h015
`define ACDF_REG_RESYNC    9'h109
`define ACDF_PWR_PD_BIT    0
`define ACDF_PWR_SBY_BIT   1
`define ACDF_FMT_OFFS_BIT  0
`define ACDF_FMT_RED_BIT   1
`define ACDF_FMT_LSB_BIT   2
`define ACDF_FMT_12B_BIT   3
`define ACDF_RS_EN_BIT     0
`define ACDF_RS_ONCE_BIT   1
`define ACDF_ST_LOCK_BIT   0
`define ACDF_ST_OVR_BIT    1
`define ACDF_ST_PD_BIT     2
`define ACDF_ST_ARM_BIT    3
`define ACDF_RST_BYTE      8'h00
`define ACDF_CLK_HZ        50_000_000
`define ACDF_DCS_MIN_HZ    20_000_000
`define ACDF_RELOCK_MIN_NS 1500
`define ACDF_RELOCK_MAX_NS 5000
`define ACDF_PAIRS_14      3'd7
`define ACDF_PAIRS_12      3'd6
`define ACDF_CODE_MAX      16'sh1FFF
`define ACDF_CODE_MIN      -16'sh2000
`endif

// ===== rtl/acdf_pkg.sv
// Types shared by the output formatter and serialiser
package acdf_pkg;
	typedef struct packed {
		logic             twelve;
		logic             lsb_first;
		logic [7:0][13:0] code;
	} acdf_frame_t;
	typedef enum logic [1:0] {
		SER_IDLE  = 2'b01,
		SER_SHIFT = 2'b10
	} acdf_ser_t;
endpackage : acdf_pkg

// ===== rtl/acdf_fifo.sv
// Small valid/ready FIFO between formatter and serialiser
`timescale 1ns/100ps
`default_nettype none
module acdf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             CLOCK,
	input  wire logic             RST_B,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// Handshake qualifiers
	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_r];

	// Storage
	always_ff @(posedge CLOCK) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else if (flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : acdf_fifo
`default_nettype wire

// ===== dv/acdf_assertions.sv
// Port-level checker for the clock stabiliser, power control and serial formatter
`timescale 1ns/100ps
`default_nettype none
module acdf_checker #(
	parameter int CLK_IN_HZ = 50_000_000
) (
	input wire logic       CLOCK,
	input wire logic       RST_B,
	input wire logic       POWER_DOWN_PIN,
	input wire logic       REG_WE,
	input wire logic [8:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       DCS_ACTIVE,
	input wire logic       CONV_PD,
	input wire logic       REF_PD,
	input wire logic       DRV_REDUCED,
	input wire logic [7:0] DRV_STRENGTH,
	input wire logic [1:0] BIT_CAPTURE_CLOCK,
	input wire logic [1:0] WORD_BOUNDARY_CLOCK,
	input wire logic       LANE_OE_B
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	// Power-down entry and standby
	property p_pd_float; POWER_DOWN_PIN [*6] |-> LANE_OE_B; endproperty
	property p_pd_power; POWER_DOWN_PIN [*6] |-> CONV_PD && REF_PD; endproperty
	property p_stby; REF_PD |-> CONV_PD; endproperty
	a_pd_float : assert property (p_pd_float) else $error("drivers not floated");
	a_pd_power : assert property (p_pd_power) else $error("pin power-down ignored");
	a_stby : assert property (p_stby) else $error("reference off, converter on");
	// Lane clocks and framing
	property p_bitclk;
		BIT_CAPTURE_CLOCK != 2'h0 |-> BIT_CAPTURE_CLOCK == 2'h2 && !LANE_OE_B;
	endproperty
	property p_wordclk; WORD_BOUNDARY_CLOCK != 2'h0 |-> BIT_CAPTURE_CLOCK == 2'h2; endproperty
	property p_frame;
		disable iff (!RST_B || POWER_DOWN_PIN || CONV_PD)
		$rose(WORD_BOUNDARY_CLOCK[1]) |-> (WORD_BOUNDARY_CLOCK == 2'h3) [*3]
			##1 WORD_BOUNDARY_CLOCK != 2'h3;
	endproperty
	a_bitclk : assert property (p_bitclk) else $error("bad bit clock");
	a_wordclk : assert property (p_wordclk) else $error("word clock outside word");
	a_frame : assert property (p_frame) else $error("bad word marker length");
	// Stabiliser and drive settings
	property p_dcs;
		CLK_IN_HZ < 20_000_000 || (REF_PD && $past(REF_PD) && $past(REF_PD, 2)) |-> !DCS_ACTIVE;
	endproperty
	property p_drv;
		REG_WE && REG_ADDR == 9'h015 |-> ##2 DRV_STRENGTH == $past(REG_WDATA, 2);
	endproperty
	property p_red;
		REG_WE && REG_ADDR == 9'h014 |-> ##2 DRV_REDUCED == $past(REG_WDATA[1], 2);
	endproperty
	a_dcs : assert property (p_dcs) else $error("stabiliser active");
	a_drv : assert property (p_drv) else $error("drive strength not applied");
	a_red : assert property (p_red) else $error("drive mode not applied");
	// Main scenarios reached
	c_frame : cover property ($rose(WORD_BOUNDARY_CLOCK[1]));
	c_stby : cover property (CONV_PD && !REF_PD);
	c_pd : cover property (REF_PD && LANE_OE_B);
endmodule : acdf_checker
bind acdf_top acdf_checker #(.CLK_IN_HZ(CLK_IN_HZ)) acdf_checker_inst (
	.CLOCK(CLOCK), .RST_B(RST_B), .POWER_DOWN_PIN(POWER_DOWN_PIN), .REG_WE(REG_WE),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .DCS_ACTIVE(DCS_ACTIVE), .CONV_PD(CONV_PD),
	.REF_PD(REF_PD), .DRV_REDUCED(DRV_REDUCED), .DRV_STRENGTH(DRV_STRENGTH),
	.BIT_CAPTURE_CLOCK(BIT_CAPTURE_CLOCK), .WORD_BOUNDARY_CLOCK(WORD_BOUNDARY_CLOCK),
	.LANE_OE_B(LANE_OE_B));
`default_nettype wire

// ===== dv/acdf_rx_model.sv
// Capture receiver model rebuilding serial words on all eight lanes
`timescale 1ns/100ps
`default_nettype none
module acdf_rx_model (
	input  wire logic            clock,
	input  wire logic            rst_b,
	input  wire logic [7:0][1:0] lane_data,
	input  wire logic [1:0]      bit_clk,
	input  wire logic [1:0]      word_clk,
	input  wire logic            oe_b,
	output logic      [7:0][13:0] word,
	output logic      [4:0]      bits,
	output logic      [15:0]     count
);
	logic [7:0][13:0] acc_r;
	logic [4:0]       cnt_r;
	logic             wc1_r;
	logic             start;
	// Word starts where the boundary marker rises
	assign start = word_clk[1] && !wc1_r;
	// Shift pairs in arrival order, publish at next start or at idle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			acc_r <= '0;
			cnt_r <= '0;
			wc1_r <= 1'b0;
			word <= '0;
			bits <= '0;
			count <= '0;
		end else begin
			wc1_r <= word_clk[1];
			if (cnt_r != 5'h0 && (start || bit_clk != 2'h2 || oe_b)) begin
				word <= acc_r;
				bits <= cnt_r;
				count <= count + 16'h0001;
			end
			if (!oe_b && bit_clk == 2'h2) begin
				for (int l = 0; l < 8; l++)
					acc_r[l] <= start ? {12'h000, lane_data[l]} : {acc_r[l][11:0], lane_data[l]};
				cnt_r <= start ? 5'h2 : cnt_r + 5'h2;
			end else begin
				cnt_r <= 5'h0;
			end
		end
	end
endmodule : acdf_rx_model
`default_nettype wire

// ===== dv/acdf_top_test.sv
// Self-checking bench for the divider, power control and serial formatter
`timescale 1ns/100ps
`default_nettype none
module acdf_top_test;
	logic             clock, rst_b, sync_in, pd_pin, reg_we, reg_re;
	logic [8:0]       reg_addr;
	logic [7:0]       reg_wdata, reg_rdata, drv_strength, rd_v;
	logic [7:0][15:0] adc_sample;
	logic [7:0][13:0] rx_word;
	logic [7:0][1:0]  lane_data;
	logic [1:0]       bit_clk, word_clk;
	logic [4:0]       rx_bits;
	logic [15:0]      rx_count;
	logic             sample_clk, dcs_active, dcs_locked, conv_pd, ref_pd, drv_reduced, lane_oe_b;
	int               n_fail = 0, total_checks = 0, cyc = 0, n, b;
	acdf_top #(.CLK_IN_HZ(50_000_000), .FIFO_DEPTH(4)) acdf_top_inst (
		.CLOCK(clock), .RST_B(rst_b), .SYNC_IN(sync_in), .POWER_DOWN_PIN(pd_pin),
		.ADC_SAMPLE(adc_sample), .REG_WE(reg_we), .REG_RE(reg_re), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .SAMPLE_CLK(sample_clk),
		.DCS_ACTIVE(dcs_active), .DCS_LOCKED(dcs_locked), .CONV_PD(conv_pd), .REF_PD(ref_pd),
		.DRV_REDUCED(drv_reduced), .DRV_STRENGTH(drv_strength), .LANE_DATA(lane_data),
		.BIT_CAPTURE_CLOCK(bit_clk), .WORD_BOUNDARY_CLOCK(word_clk), .LANE_OE_B(lane_oe_b));
	acdf_rx_model acdf_rx_model_inst (.clock(clock), .rst_b(rst_b), .lane_data(lane_data),
		.bit_clk(bit_clk), .word_clk(word_clk), .oe_b(lane_oe_b), .word(rx_word),
		.bits(rx_bits), .count(rx_count));
	// Clock and hang guard
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			complete_run();
		end
	end
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [8:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_we = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_we = 1'b0;
	endtask : wr
	task rd(input logic [8:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_re = 1'b1;
		reg_addr = a;
		@(negedge clock);
		reg_re = 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask : rd
	// Cycles until the next rising sample clock
	task rise(output int c);
		logic p;
		p = sample_clk;
		c = 0;
		while (c < 64) begin
			@(posedge clock);
			#1;
			c++;
			if (sample_clk && !p) return;
			p = sample_clk;
		end
	endtask : rise
	task sync_dist(input int off, output int d);
		rise(d);
		repeat (off) @(negedge clock);
		sync_in = 1'b1;
		rise(d);
		@(negedge clock);
		sync_in = 1'b0;
		repeat (3) @(negedge clock);
	endtask : sync_dist
	task wait_words(input int w);
		int s;
		s = rx_count;
		for (int k = 0; k < 400 && rx_count < s + w; k++) @(negedge clock);
		chk("words", 1, rx_count >= s + w);
	endtask : wait_words
	function automatic logic [13:0] expw(input logic signed [15:0] s, input logic [3:0] f);
		logic [13:0] c, e;
		int          w;
		c = (s > 16'sh1FFF) ? 14'h1FFF : (s < -16'sh2000) ? 14'h2000 : s[13:0];
		c[13] = c[13] ^ f[0];
		w = f[3] ? 12 : 14;
		e = '0;
		for (int k = 0; k < w; k++) e[w - 1 - k] = f[2] ? c[k + 14 - w] : c[13 - k];
		return e;
	endfunction : expw
	task t_regs;
		chk("drv_mode", 0, drv_reduced);
		rd(9'h015, rd_v);
		chk("drv_rst", 0, rd_v);
		chk("dcs_on", 1, dcs_active);
		wr(9'h015, 8'hA5);
		rd(9'h015, rd_v);
		chk("drv_rd", 8'hA5, rd_v);
		chk("drv_out", 8'hA5, drv_strength);
		wr(9'h014, 8'h02);
		@(negedge clock);
		chk("reduced", 1, drv_reduced);
		wr(9'h014, 8'h00);
		wr(9'h1FF, 8'hFF);
		rd(9'h1FF, rd_v);
		chk("unmapped", 0, rd_v);
		rd(9'h109, rd_v);
		chk("resync_rst", 0, rd_v);
	endtask : t_regs
	task t_div;
		for (int r = 0; r < 8; r++) begin
			wr(9'h00B, r[7:0]);
			if (r == 0) begin
				repeat (3) @(negedge clock);
				chk("div1_high", 1, sample_clk);
			end else begin
				rise(n);
				rise(n);
				rise(n);
				chk("div_period", r + 1, n);
			end
		end
	endtask : t_div
	task t_sync;
		wr(9'h00B, 8'h07);
		wr(9'h109, 8'h01);
		sync_dist(2, b);
		sync_dist(3, n);
		chk("sync_every", b, n);
		wr(9'h109, 8'h03);
		rd(9'h00C, rd_v);
		chk("armed", 1, rd_v[3]);
		sync_dist(2, n);
		chk("sync_first", b, n);
		sync_dist(3, n);
		chk("sync_later", 1, n != b);
	endtask : t_sync
	task t_power;
		@(negedge clock);
		pd_pin = 1'b1;
		repeat (6) @(negedge clock);
		chk("oe_pd", 1, lane_oe_b);
		chk("pd_pin", 2'h3, {conv_pd, ref_pd});
		pd_pin = 1'b0;
		repeat (6) @(negedge clock);
		chk("pd_exit", 3'h0, {conv_pd, ref_pd, lane_oe_b});
		wait_words(2);
		wr(9'h008, 8'h01);
		repeat (3) @(negedge clock);
		chk("pd_reg", 3'h7, {conv_pd, ref_pd, lane_oe_b});
		wr(9'h008, 8'h02);
		repeat (3) @(negedge clock);
		chk("standby", 2'h2, {conv_pd, ref_pd});
		wr(9'h008, 8'h00);
	endtask : t_power
	task t_stream;
		logic [3:0] fmts [5];
		fmts = '{4'h0, 4'h1, 4'h4, 4'h8, 4'hD};
		wr(9'h00B, 8'h06);
		for (int k = 0; k < 400 && dcs_locked !== 1'b1; k++) @(negedge clock);
		chk("locked", 1, dcs_locked);
		foreach (fmts[i]) begin
			wr(9'h014, {4'h0, fmts[i]});
			wait_words(6);
			chk("bits", fmts[i][3] ? 12 : 14, rx_bits);
			for (int l = 0; l < 8; l++) chk("lane", expw(adc_sample[l], fmts[i]), rx_word[l]);
		end
	endtask : t_stream
	// Main sequence
	initial begin
		rst_b = 1'b0;
		sync_in = 1'b0;
		pd_pin = 1'b0;
		reg_we = 1'b0;
		reg_re = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		adc_sample = {16'sh0ABC, -16'sh0001, 16'sh0123, -16'sh2000, 16'sh1FFF, 16'sh0000,
			-16'sh3000, 16'sh3000};
		repeat (5) @(negedge clock);
		chk("oe_reset", 1, lane_oe_b);
		rst_b = 1'b1;
		@(negedge clock);
		t_regs();
		t_div();
		t_sync();
		t_power();
		t_stream();
		complete_run();
	end
endmodule : acdf_top_test
`default_nettype wire
